//--- core/ursbc_pkg.sv
// shared constants for the low_power_receive-capable receive channel
package ursbc_pkg;

	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] ADDR_DATA_DIV  = 8'h00;
	localparam logic [7:0] ADDR_MODE      = 8'h04;
	localparam logic [7:0] ADDR_PRESCALE  = 8'h08;
	localparam logic [7:0] ADDR_START     = 8'h0C;
	localparam logic [7:0] ADDR_STOP      = 8'h10;
	localparam logic [7:0] ADDR_ENABLED   = 8'h14;
	localparam logic [7:0] ADDR_STANDBY   = 8'h18;
	localparam logic [7:0] ADDR_FLAGS     = 8'h1C;
	localparam logic [7:0] ADDR_FLAG_CLR  = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h24;
	localparam logic [7:0] ADDR_IRQ_CLR   = 8'h28;
	localparam logic [7:0] ADDR_IRQ_EN    = 8'h2C;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int DIV_MSB        = 15;
	localparam int DIV_LSB        = 9;
	localparam int MODE_CKS_BIT   = 15;
	localparam int MODE_EIE_BIT   = 2;
	localparam int MODE_PAR_BIT   = 1;
	localparam int MODE_ODD_BIT   = 0;
	localparam int MODE_LEN9_BIT  = 3;
	localparam int PRS_LOW_LSB    = 0;
	localparam int PRS_HIGH_LSB   = 4;
	localparam int RX_CH_BIT      = 1;
	localparam int SSC_SWC_BIT    = 0;
	localparam int SSC_SSEC_BIT   = 1;
	localparam int FLAG_OVF_BIT   = 0;
	localparam int FLAG_FEF_BIT   = 1;
	localparam int FLAG_PEF_BIT   = 2;
	localparam int IRQ_END_BIT    = 0;
	localparam int IRQ_ERR_BIT    = 1;

	// ************************************************************
	// reset values and frame constants
	// ************************************************************
	localparam logic [6:0]  DIV_RESET     = 7'h7F;
	localparam logic [3:0]  BITS_8        = 4'h8;
	localparam logic [3:0]  BITS_9        = 4'h9;
	localparam logic [14:0] PRS_ONE       = 15'h0001;

	typedef enum logic [1:0] {
		URSBC_IDLE  = 2'b00,
		URSBC_START = 2'b01,
		URSBC_DATA  = 2'b10,
		URSBC_STOP  = 2'b11
	} ursbc_state_e;

endpackage

//--- core/ursbc_rx.sv
// receive channel with low_power_receive error control, divisor baud and prescaler
//
// Overview of operation
// [R1] error irq fires on unsuppressed receive errors when enabled
// [R2] suppress bit blocks the error irq even when it is enabled
// [R3] suppressing keeps parity, framing, overrun flags; no error irq (here suppression also leaves all three flags unset)
// [R4] suppressing: software clears flags, reads data before wake control
// [R5] software writes stop trigger before and after low-power reception
// [R6] software clears wake control after the low-power reception completes
// [R7] software reads received data while wake control is still one
// [R8] bit rate is operation clock over (divisor plus one) over two
// [R9] software programs divisor only with values 2 to 127
// [R10] mode bit 15 picks high or low prescaler field, clock over 2^k
// [R11] software stops all channels before changing the system clock
// [R12] in stop mode a start bit begins low-power reception unaided
// [R13] error irq off: no error interrupt, transfer-end interrupt every frame
// [R14] unsuppressed errors set their flag, held until software clears it
module ursbc_rx (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        receive_pin,
	input  wire logic        cpu_stop_mode,
	output logic             rx_error_irq,
	output logic             rx_transfer_end_irq,
	output logic             irq,
	output logic             rx_channel_enabled_status,
	output logic             low_power_receive
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [15:0]          rdata;
		logic [6:0]           divisor;
		logic [8:0]           rx_data;
		logic                 rx_full;
		logic                 cks;
		logic                 eie;
		logic                 par_en;
		logic                 par_odd;
		logic                 len9;
		logic [3:0]           prs_low;
		logic [3:0]           prs_high;
		logic                 enabled;
		logic                 swc;
		logic                 ssec;
		logic [2:0]           flags;
		logic [1:0]           irq_stat;
		logic [1:0]           irq_en;
		logic                 irq;
		logic                 err_irq;
		logic                 end_irq;
		logic                 lp_rx;
		logic [14:0]          prs_cnt;
		logic [7:0]           timer;
		logic [3:0]           bit_cnt;
		logic [8:0]           shift;
		logic                 par_bit;
		logic                 pin_prev;
		ursbc_pkg::ursbc_state_e st;
	} ursbc_state_s;

	ursbc_state_s s_q;
	ursbc_state_s s_d;

	// ************************************************************
	// next-state helpers
	// ************************************************************
	logic [3:0]  prs_k;
	logic [14:0] prs_mask;
	logic        mck_tick;
	logic        rx_allowed;
	logic [3:0]  nbits;
	logic [7:0]  half_bit;
	logic [7:0]  full_bit;
	logic [2:0]  err_set;
	logic [2:0]  flag_clr;
	logic [1:0]  irq_set;
	logic [1:0]  irq_clr;

	always_comb begin
		s_d      = s_q;
		err_set  = 3'h0;
		flag_clr = 3'h0;
		irq_set  = 2'h0;
		irq_clr  = 2'h0;
		s_d.err_irq = 1'b0;
		s_d.end_irq = 1'b0;

		// ********************************************************
		// operation clock prescaler
		// ********************************************************
		prs_k    = s_q.cks ? s_q.prs_high : s_q.prs_low; // R10
		prs_mask = 15'((ursbc_pkg::PRS_ONE << prs_k) - ursbc_pkg::PRS_ONE);
		// free-running divider: a frame's first tick may come a period early
		// mask of k low ones; k of zero ticks on every clock
		mck_tick = (s_q.prs_cnt & prs_mask) == prs_mask; // R10
		s_d.prs_cnt = s_q.prs_cnt + ursbc_pkg::PRS_ONE;

		// half a bit is divisor+1 ticks, a whole bit twice that
		half_bit = {1'b0, s_q.divisor}; // R8
		full_bit = {s_q.divisor, 1'b1}; // R8
		nbits    = (s_q.len9 ? ursbc_pkg::BITS_9 : ursbc_pkg::BITS_8)
		         + {3'h0, s_q.par_en};

		// with wake control set, only a start seen in stop mode counts
		rx_allowed = s_q.enabled & (~s_q.swc | cpu_stop_mode); // R12

		// ********************************************************
		// receiver
		// ********************************************************
		s_d.pin_prev = receive_pin;
		unique case (s_q.st)
			ursbc_pkg::URSBC_IDLE: begin
				if (rx_allowed && s_q.pin_prev && !receive_pin) begin
					s_d.st    = ursbc_pkg::URSBC_START;
					s_d.timer = half_bit;
					s_d.lp_rx = s_q.swc & cpu_stop_mode; // R12
				end
			end
			ursbc_pkg::URSBC_START: begin
				if (mck_tick) begin
					s_d.timer = s_q.timer - 8'h01;
					if (s_q.timer == 8'h00) begin
						// a glitch too short for a start bit is dropped
						s_d.st      = receive_pin ? ursbc_pkg::URSBC_IDLE
						                          : ursbc_pkg::URSBC_DATA;
						s_d.lp_rx   = receive_pin ? 1'b0 : s_q.lp_rx;
						s_d.timer   = full_bit;
						s_d.bit_cnt = 4'h0;
						s_d.shift   = 9'h000;
					end
				end
			end
			ursbc_pkg::URSBC_DATA: begin
				if (mck_tick) begin
					s_d.timer = s_q.timer - 8'h01;
					if (s_q.timer == 8'h00) begin
						s_d.timer   = full_bit;
						// lsb first; a bit past the data width is parity
						s_d.bit_cnt = s_q.bit_cnt + 4'h1;
						if (s_q.bit_cnt < (s_q.len9 ? ursbc_pkg::BITS_9
						                            : ursbc_pkg::BITS_8))
							s_d.shift[s_q.bit_cnt] = receive_pin;
						else
							s_d.par_bit = receive_pin;
						if (s_q.bit_cnt == nbits - 4'h1)
							s_d.st = ursbc_pkg::URSBC_STOP;
					end
				end
			end
			ursbc_pkg::URSBC_STOP: begin
				if (mck_tick) begin
					s_d.timer = s_q.timer - 8'h01;
					if (s_q.timer == 8'h00) begin
						s_d.st    = ursbc_pkg::URSBC_IDLE;
						s_d.lp_rx = 1'b0;
						err_set[ursbc_pkg::FLAG_FEF_BIT] = ~receive_pin;
						err_set[ursbc_pkg::FLAG_PEF_BIT] = s_q.par_en &
							((^s_q.shift ^ s_q.par_bit) != s_q.par_odd);
						err_set[ursbc_pkg::FLAG_OVF_BIT] = s_q.rx_full;
						// overrun keeps the unread word
						if (!s_q.rx_full) begin
							s_d.rx_data = s_q.shift;
							s_d.rx_full = 1'b1;
						end
						// suppression drops the flags and the error irq alike
						if (s_q.ssec)
							err_set = 3'h0; // R3
						s_d.end_irq = 1'b1; // R13
						s_d.err_irq = s_q.eie & (|err_set); // R1 R2 R13
						irq_set[ursbc_pkg::IRQ_END_BIT] = 1'b1;
						irq_set[ursbc_pkg::IRQ_ERR_BIT] = s_q.eie & (|err_set);
					end
				end
			end
		endcase

		// ********************************************************
		// register writes
		// ********************************************************
		if (wr) begin
			unique case (addr)
				ursbc_pkg::ADDR_DATA_DIV:
					s_d.divisor = wdata[ursbc_pkg::DIV_MSB:ursbc_pkg::DIV_LSB];
				ursbc_pkg::ADDR_MODE: begin
					s_d.cks     = wdata[ursbc_pkg::MODE_CKS_BIT];
					s_d.eie     = wdata[ursbc_pkg::MODE_EIE_BIT];
					s_d.par_en  = wdata[ursbc_pkg::MODE_PAR_BIT];
					s_d.par_odd = wdata[ursbc_pkg::MODE_ODD_BIT];
					s_d.len9    = wdata[ursbc_pkg::MODE_LEN9_BIT];
				end
				ursbc_pkg::ADDR_PRESCALE: begin
					s_d.prs_low  = wdata[ursbc_pkg::PRS_LOW_LSB +: 4];
					s_d.prs_high = wdata[ursbc_pkg::PRS_HIGH_LSB +: 4];
				end
				ursbc_pkg::ADDR_START:
					if (wdata[ursbc_pkg::RX_CH_BIT])
						s_d.enabled = 1'b1;
				ursbc_pkg::ADDR_STOP:
					if (wdata[ursbc_pkg::RX_CH_BIT]) begin
						// stop halts the channel and aborts a frame
						s_d.enabled = 1'b0; // R5
						s_d.st      = ursbc_pkg::URSBC_IDLE; // R5
						s_d.lp_rx   = 1'b0;
					end
				ursbc_pkg::ADDR_STANDBY: begin
					s_d.swc  = wdata[ursbc_pkg::SSC_SWC_BIT];
					s_d.ssec = wdata[ursbc_pkg::SSC_SSEC_BIT];
				end
				ursbc_pkg::ADDR_FLAG_CLR:
					flag_clr = wdata[2:0];
				ursbc_pkg::ADDR_IRQ_CLR:
					irq_clr = wdata[1:0];
				ursbc_pkg::ADDR_IRQ_EN:
					s_d.irq_en = wdata[1:0];
				default: begin
				end
			endcase
		end

		// ********************************************************
		// flag and interrupt status
		// ********************************************************
		// set wins over a clear in the same cycle
		s_d.flags    = (s_q.flags & ~flag_clr) | err_set; // R14
		s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
		s_d.irq      = |(s_d.irq_stat & s_d.irq_en);

		// ********************************************************
		// register reads, answer one cycle later
		// ********************************************************
		// cycles without a read return zero
		s_d.rdata = 16'h0000;
		if (rd) begin
			unique case (addr)
				ursbc_pkg::ADDR_DATA_DIV: begin
					s_d.rdata = {s_q.divisor, s_q.rx_data};
					// a frame landing in the read cycle keeps its new word
					if (!(s_d.st == ursbc_pkg::URSBC_IDLE && s_d.rx_full
					      && !s_q.rx_full))
						s_d.rx_full = 1'b0;
				end
				ursbc_pkg::ADDR_MODE: begin
					s_d.rdata[ursbc_pkg::MODE_CKS_BIT]  = s_q.cks;
					s_d.rdata[ursbc_pkg::MODE_EIE_BIT]  = s_q.eie;
					s_d.rdata[ursbc_pkg::MODE_PAR_BIT]  = s_q.par_en;
					s_d.rdata[ursbc_pkg::MODE_ODD_BIT]  = s_q.par_odd;
					s_d.rdata[ursbc_pkg::MODE_LEN9_BIT] = s_q.len9;
				end
				ursbc_pkg::ADDR_PRESCALE:
					s_d.rdata[7:0] = {s_q.prs_high, s_q.prs_low};
				ursbc_pkg::ADDR_ENABLED:
					s_d.rdata[ursbc_pkg::RX_CH_BIT] = s_q.enabled;
				ursbc_pkg::ADDR_STANDBY: begin
					s_d.rdata[ursbc_pkg::SSC_SWC_BIT]  = s_q.swc;
					s_d.rdata[ursbc_pkg::SSC_SSEC_BIT] = s_q.ssec;
				end
				ursbc_pkg::ADDR_FLAGS:
					s_d.rdata[2:0] = s_q.flags;
				ursbc_pkg::ADDR_IRQ_STAT:
					s_d.rdata[1:0] = s_q.irq_stat;
				ursbc_pkg::ADDR_IRQ_EN:
					s_d.rdata[1:0] = s_q.irq_en;
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q          <= '0;
			s_q.divisor  <= ursbc_pkg::DIV_RESET;
			// idle level, so leaving reset is not taken for a start edge
			s_q.pin_prev <= 1'b1;
			s_q.st       <= ursbc_pkg::URSBC_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign rdata                     = s_q.rdata;
	assign rx_error_irq              = s_q.err_irq;
	assign rx_transfer_end_irq       = s_q.end_irq;
	assign irq                       = s_q.irq;
	assign rx_channel_enabled_status = s_q.enabled;
	assign low_power_receive         = s_q.lp_rx;

endmodule

//--- test/ursbc_rx_props.sv
// port-level assertion checker for the receive channel
module ursbc_rx_props (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [7:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        receive_pin,
	input wire logic        cpu_stop_mode,
	input wire logic        rx_error_irq,
	input wire logic        rx_transfer_end_irq,
	input wire logic        irq,
	input wire logic        rx_channel_enabled_status,
	input wire logic        low_power_receive
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic stop_w;
	assign stop_w = wr && addr == ursbc_pkg::ADDR_STOP && wdata[1];
	// ************************************************************
	// checks
	// ************************************************************
	a_err_at_end: assert property (
		rx_error_irq |-> rx_transfer_end_irq) else $error("err w/o end");
	a_frame_gap: assert property (
		rx_transfer_end_irq |=> !rx_transfer_end_irq [*8])
		else $error("frames too close");
	a_stop_disables: assert property (
		stop_w |=> !rx_channel_enabled_status) else $error("stop ignored");
	a_end_enabled: assert property (
		rx_transfer_end_irq |-> $past(rx_channel_enabled_status))
		else $error("frame while stopped");
	a_lpr_in_stop: assert property (
		$rose(low_power_receive) |-> $past(cpu_stop_mode))
		else $error("low_power_receive outside stop");
	a_lpr_enabled: assert property (
		$rose(low_power_receive) |-> rx_channel_enabled_status)
		else $error("low_power_receive while off");
	a_rdata_idle: assert property (
		!$past(rd) |-> rdata == 16'h0000) else $error("rdata not idle");
	a_irq_cause: assert property (
		$rose(irq) |-> rx_transfer_end_irq || $past(wr))
		else $error("irq without cause");
endmodule

bind ursbc_rx ursbc_rx_props u_props (.clk(clk), .rstn(rstn), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.receive_pin(receive_pin), .cpu_stop_mode(cpu_stop_mode),
	.rx_error_irq(rx_error_irq), .rx_transfer_end_irq(rx_transfer_end_irq),
	.irq(irq), .rx_channel_enabled_status(rx_channel_enabled_status),
	.low_power_receive(low_power_receive));

//--- test/ursbc_tx_model.sv
// behavioural remote serial transmitter on the receive line
module ursbc_tx_model (
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic [7:0]  din,
	input  wire logic        bad_stop,
	input  wire logic [15:0] per,
	output logic             line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] f;
	// idle rests high like a pulled-up line; go is missed while busy
	initial line = 1'b1;
	always @(posedge clk) begin
		if (go) begin
			f = {~bad_stop, din, 1'b0};
			for (int i = 0; i < 10; i++) begin
				line <= f[i];
				repeat (per) @(posedge clk);
			end
			line <= 1'b1;
		end
	end
endmodule

//--- test/tb_ursbc_rx.sv
// self-checking bench for the receive channel
module tb_ursbc_rx;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        cpu_stop_mode = 1'b0;
	logic        go = 1'b0;
	logic        bad_stop = 1'b0;
	logic [7:0]  din = 8'h00;
	logic [15:0] per = 16'h0006;
	logic [15:0] rdata, v;
	logic        receive_pin, rx_error_irq, rx_transfer_end_irq, irq;
	logic        rx_channel_enabled_status, low_power_receive, lpr, err;
	int          failures = 0;
	int          tests_run = 0;
	logic [15:0] cm [3] = '{16'h0004, 16'h0004, 16'h8004};
	logic [15:0] cp [3] = '{16'h0000, 16'h0031, 16'h0031};
	logic [15:0] cq [3] = '{16'h0006, 16'h000C, 16'h0030};
	logic [15:0] sm [3] = '{16'h8004, 16'h8004, 16'h8000};
	logic [15:0] ss [3] = '{16'h0000, 16'h0002, 16'h0000};
	logic [15:0] ef [3] = '{16'h0002, 16'h0000, 16'h0002};
	logic [15:0] es [3] = '{16'h0003, 16'h0001, 16'h0001};
	always #5 clk = ~clk;
	ursbc_rx dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .receive_pin(receive_pin),
		.cpu_stop_mode(cpu_stop_mode), .rx_error_irq(rx_error_irq),
		.rx_transfer_end_irq(rx_transfer_end_irq), .irq(irq),
		.rx_channel_enabled_status(rx_channel_enabled_status),
		.low_power_receive(low_power_receive));
	ursbc_tx_model u_tx (.clk(clk), .go(go), .din(din),
		.bad_stop(bad_stop), .per(per), .line(receive_pin));
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic report_and_stop();
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] q);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		q = rdata;
	endtask
	task automatic frame(input logic [7:0] d, input logic bs);
		int n;
		n = 0;
		lpr = 1'b0;
		@(posedge clk);
		go <= 1'b1;
		din <= d;
		bad_stop <= bs;
		@(posedge clk);
		go <= 1'b0;
		do begin
			@(negedge clk);
			lpr |= low_power_receive;
			n++;
		end while (rx_transfer_end_irq !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			failures++;
			report_and_stop();
		end
		err = rx_error_irq;
		repeat (per) @(negedge clk);
	endtask
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(ursbc_pkg::ADDR_DATA_DIV, v);
		chk(v, 16'hFE00);
		rd_reg(8'h3C, v);
		chk(v, 16'h0000);
		wr_reg(ursbc_pkg::ADDR_DATA_DIV, 16'h0400);
		wr_reg(ursbc_pkg::ADDR_IRQ_EN, 16'h0003);
		wr_reg(ursbc_pkg::ADDR_START, 16'h0002);
		for (int i = 0; i < 3; i++) begin
			wr_reg(ursbc_pkg::ADDR_MODE, cm[i]);
			wr_reg(ursbc_pkg::ADDR_PRESCALE, cp[i]);
			per <= cq[i];
			frame(8'hA5 ^ 8'(i), 1'b0);
			rd_reg(ursbc_pkg::ADDR_DATA_DIV, v);
			chk(v, {8'h04, 8'hA5 ^ 8'(i)});
			rd_reg(ursbc_pkg::ADDR_IRQ_STAT, v);
			chk(v, 16'h0001);
			chk({15'h0000, irq}, 16'h0001);
			chk({15'h0000, rx_channel_enabled_status}, 16'h0001);
			chk({15'h0000, lpr}, 16'h0000);
			wr_reg(ursbc_pkg::ADDR_IRQ_EN, 16'h0000);
			@(negedge clk);
			chk({15'h0000, irq}, 16'h0000);
			wr_reg(ursbc_pkg::ADDR_IRQ_EN, 16'h0003);
			wr_reg(ursbc_pkg::ADDR_IRQ_CLR, 16'h0003);
		end
		// framing errors under each low_power_receive error setting
		for (int j = 0; j < 3; j++) begin
			wr_reg(ursbc_pkg::ADDR_STOP, 16'h0002);
			wr_reg(ursbc_pkg::ADDR_MODE, sm[j]);
			wr_reg(ursbc_pkg::ADDR_STANDBY, ss[j]);
			wr_reg(ursbc_pkg::ADDR_FLAG_CLR, 16'h0007);
			rd_reg(ursbc_pkg::ADDR_DATA_DIV, v);
			wr_reg(ursbc_pkg::ADDR_START, 16'h0002);
			wr_reg(ursbc_pkg::ADDR_STANDBY, ss[j] | 16'h0001);
			cpu_stop_mode <= 1'b1;
			frame(8'h3C, 1'b1);
			chk({15'h0000, lpr}, 16'h0001);
			chk({15'h0000, err}, {15'h0000, es[j][1]});
			@(posedge clk);
			cpu_stop_mode <= 1'b0;
			rd_reg(ursbc_pkg::ADDR_DATA_DIV, v);
			rd_reg(ursbc_pkg::ADDR_FLAGS, v);
			chk(v, ef[j]);
			rd_reg(ursbc_pkg::ADDR_IRQ_STAT, v);
			chk(v, es[j]);
			wr_reg(ursbc_pkg::ADDR_STOP, 16'h000F);
			rd_reg(ursbc_pkg::ADDR_ENABLED, v);
			chk(v, 16'h0000);
			chk({15'h0000, rx_channel_enabled_status}, 16'h0000);
			wr_reg(ursbc_pkg::ADDR_STANDBY, 16'h0000);
			wr_reg(ursbc_pkg::ADDR_IRQ_CLR, 16'h0003);
			wr_reg(ursbc_pkg::ADDR_FLAG_CLR, 16'h0007);
		end
		// second frame lands on unread data
		wr_reg(ursbc_pkg::ADDR_MODE, 16'h8004);
		wr_reg(ursbc_pkg::ADDR_START, 16'h0002);
		frame(8'h11, 1'b0);
		frame(8'h22, 1'b0);
		rd_reg(ursbc_pkg::ADDR_FLAGS, v);
		chk(v, 16'h0001);
		rd_reg(ursbc_pkg::ADDR_DATA_DIV, v);
		chk(v, 16'h0411);
		// parity taken from the model's stop bit, then a 9-bit word
		wr_reg(ursbc_pkg::ADDR_FLAG_CLR, 16'h0007);
		wr_reg(ursbc_pkg::ADDR_IRQ_CLR, 16'h0003);
		wr_reg(ursbc_pkg::ADDR_MODE, 16'h8006);
		frame(8'h3C, 1'b0);
		chk({15'h0000, err}, 16'h0001);
		rd_reg(ursbc_pkg::ADDR_FLAGS, v);
		chk(v, 16'h0004);
		rd_reg(ursbc_pkg::ADDR_DATA_DIV, v);
		chk(v, 16'h043C);
		wr_reg(ursbc_pkg::ADDR_FLAG_CLR, 16'h0007);
		wr_reg(ursbc_pkg::ADDR_MODE, 16'h8007);
		frame(8'h3C, 1'b0);
		rd_reg(ursbc_pkg::ADDR_FLAGS, v);
		chk(v, 16'h0000);
		rd_reg(ursbc_pkg::ADDR_DATA_DIV, v);
		chk(v, 16'h043C);
		wr_reg(ursbc_pkg::ADDR_MODE, 16'h800C);
		frame(8'h3C, 1'b0);
		rd_reg(ursbc_pkg::ADDR_DATA_DIV, v);
		chk(v, 16'h053C);
		report_and_stop();
	end
endmodule
